// *** inc/rcs_regs.svh ***
`ifndef RCS_REGS_SVH
`define RCS_REGS_SVH

// byte addresses on the register bus
`define RCS_ADDR_VDET 12'hd0c
`define RCS_ADDR_RCTL 12'hf00
`define RCS_ADDR_P2SEL 12'hf04
`define RCS_ADDR_COMBO 12'hf08
`define RCS_ADDR_P3SEL 12'hf0c
`define RCS_ADDR_ROUTE 12'hf10
`define RCS_ADDR_IRQST 12'hf14
`define RCS_ADDR_IRQMSK 12'hf18

// reset values
`define RCS_RST_RCTL 8'h20
`define RCS_RST_COMBO 8'h00
`define RCS_VDET_FILL 5'h1f

// field positions
`define RCS_VD_EN 0
`define RCS_VD_LV 1
`define RCS_VD_HV 2
`define RCS_VD_FILL_LO 3
`define RCS_VD_FILL_HI 7
`define RCS_RC_STOP 7
`define RCS_RC_PRESC 0
`define RCS_RC_DELAY 5
`define RCS_RC_LEVEL 6
`define RCS_RC_SRC_HI 4
`define RCS_RC_SRC_LO 2
`define RCS_CB_SEL_HI 3
`define RCS_CB_SEL_LO 1
`define RCS_CB_LEVEL 4
`define RCS_RT_VALID 0
`define RCS_RT_ONWR 1
`define RCS_RT_EN 4
`define RCS_IRQ_LV 0
`define RCS_IRQ_WAKE 1

// primary source codes
`define RCS_SRC_P31 3'h2
`define RCS_SRC_P32 3'h3
`define RCS_SRC_P33 3'h4
`define RCS_SRC_P27 3'h5
`define RCS_SRC_NORA 3'h6
`define RCS_SRC_NORB 3'h7

// restart addresses
`define RCS_RESTART_ADDR 12'h00c
`define RCS_POR_ADDR 12'h000

// timing
`define RCS_CLK_NS 50
`define RCS_STARTUP_DELAY_TIMER_NS 5000000
`define RCS_TMR_W 20

`endif

// *** inc/rcs_pkg.sv ***
package rcs_pkg;

  typedef enum logic [2:0] {
    RCS_HOLD,
    RCS_TIMING,
    RCS_RUN,
    RCS_HALT,
    RCS_STOP
  } rcs_state_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } rcs_apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } rcs_apb_rsp_t;

endpackage : rcs_pkg

// *** src/rcs_sequencer.sv ***
// Operation
// - stop flag reads 0 after full resets, set to 1 by stop recovery
// - full resets default everything; recovery keeps a designated subset of bits
// - reset held while brown-out active, then full power-on sequence
// - voltage-detect bit 0 enables continuous flag updates from comparators
// - voltage-detect bit 2 reads 1 only while supply above high threshold
// - voltage-detect bit 1 reads 1 only while supply below low threshold
// - low flag latches low-voltage interrupt until cleared; mask gates service
// - voltage-detect bits 7..3 read ones, writes ignored
// - detection inactive in stop; software disables it before stop
// - halt stops only the cpu clock; oscillator and interrupts keep running
// - halt ends when an enabled interrupt is taken
// - stop turns off internal clock and oscillator
// - stop ends only by reset or recovery; restart at fixed address
// - route enable sends recovery events to wake interrupt and port 3 bit 3
// - primary selector picks port 3 pin, port 2 pin 7 or port 2 combination at a level
// - per-pin change detectors on port 2 and port 3 against latched value
// - secondary selector picks one of seven pin combinations at a level
// - routing register reports latch valid and read-or-write capture
// - any configured wake source active raises a recovery event
// - startup timer runs after power-on, brown-out, delayed recovery, watchdog
// - clock prescaler disabled by power-on reset and stop recovery
`timescale 1ns/1ps
`include "rcs_regs.svh"

module rcs_sequencer #(
  parameter int unsigned STARTUP_CYCLES = `RCS_STARTUP_DELAY_TIMER_NS / `RCS_CLK_NS
) (
  input wire logic core_clk,
  input wire logic nrst,
  input wire rcs_pkg::rcs_apb_req_t apbReq,
  output rcs_pkg::rcs_apb_rsp_t apbRsp,
  input wire logic porReq,
  input wire logic brownOut,
  input wire logic wdtTimeout,
  input wire logic lvCompare,
  input wire logic hvCompare,
  input wire logic haltReq,
  input wire logic stopReq,
  input wire logic irqPending,
  input wire logic [7:0] port2In,
  input wire logic [3:0] port3In,
  input wire logic [7:0] port2IsOutput,
  input wire logic [3:0] port3IsOutput,
  input wire logic port2Rd,
  input wire logic port2Wr,
  input wire logic [7:0] port2WrData,
  input wire logic port3Rd,
  input wire logic port3Wr,
  input wire logic [3:0] port3WrData,
  output logic sysRstN,
  output logic cpuClkEn,
  output logic oscEn,
  output logic prescaleEn,
  output logic [11:0] restartAddr,
  output logic lowVoltageIrq,
  output logic wakeIrq,
  output logic port3Bit3Low
);
  import rcs_pkg::*;

  typedef struct packed {
    rcs_state_t st;
    logic [`RCS_TMR_W-1:0] tmr;
    logic vdEn;
    logic lvFlag;
    logic hvFlag;
    logic lvPend;
    logic maskLv;
    logic maskWake;
    logic stopFlag;
    logic [7:0] rctl;
    logic [7:0] p2Sel;
    logic [7:0] combo;
    logic [3:0] p3Sel;
    logic routeEn;
    logic latValid;
    logic latOnWr;
    logic [7:0] lat2;
    logic [3:0] lat3;
    logic wakePrev;
    logic sysRstN;
    logic cpuClkEn;
    logic oscEn;
    logic prescEn;
    logic [11:0] rstAddr;
    logic lvIrq;
    logic wakeIrq;
    logic p3b3Low;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } rcs_state_reg_t;

  localparam logic [`RCS_TMR_W-1:0] TMR_LOAD = `RCS_TMR_W'(STARTUP_CYCLES - 1);

  rcs_state_reg_t s_q;
  rcs_state_reg_t s_d;

  function automatic rcs_state_reg_t fullDefault();
    rcs_state_reg_t r;
    r = '0;
    r.st = RCS_TIMING;
    r.tmr = TMR_LOAD;
    r.rctl = `RCS_RST_RCTL;
    r.combo = `RCS_RST_COMBO;
    r.oscEn = 1'b1;
    r.rstAddr = `RCS_POR_ADDR;
    return r;
  endfunction : fullDefault

  // secondary combinations of the usable pins; code 0 selects nothing
  function automatic logic comboLogic(input logic [2:0] sel, input logic [7:0] p2,
                                      input logic [3:0] p3);
    logic v;
    v = 1'b0;
    unique case (sel)
      3'h0: v = 1'b0;
      3'h1: v = p3[1] & p2[0];
      3'h2: v = p3[2] & p2[1];
      3'h3: v = p3[3] & p2[2];
      3'h4: v = p3[1] | p3[2] | p3[3];
      3'h5: v = ~(p2[4] | p2[5] | p2[6] | p2[7]);
      3'h6: v = p2[7] & p3[1];
      3'h7: v = ~(p2[0] | p2[1] | p2[2] | p2[3] | p3[1]);
    endcase
    return v;
  endfunction : comboLogic

  // a level source counts only when its pin is usable and meets the programmed level
  function automatic logic levelHit(input logic usable, input logic pin, input logic level);
    return usable & (pin == level);
  endfunction : levelHit

  // pins driven as outputs or watched by a change detector are left out
  logic [7:0] use2;
  logic [3:0] use3;
  logic [7:0] pin2;
  logic [3:0] pin3;
  logic primEvt;
  logic comboEvt;
  logic changeEvt;
  logic wakeEvt;
  logic apbAcc;
  logic apbHit;
  logic apbFirst;
  logic [31:0] rdMux;
  logic [7:0] wdat;

  always_comb
  begin
    use2 = ~port2IsOutput & ~s_q.p2Sel;
    use3 = ~port3IsOutput & ~s_q.p3Sel;
    pin2 = port2In & use2;
    pin3 = port3In & use3;
    primEvt = 1'b0;
    unique case (s_q.rctl[`RCS_RC_SRC_HI:`RCS_RC_SRC_LO])
      `RCS_SRC_P31: primEvt = levelHit(use3[1], port3In[1], s_q.rctl[`RCS_RC_LEVEL]);
      `RCS_SRC_P32: primEvt = levelHit(use3[2], port3In[2], s_q.rctl[`RCS_RC_LEVEL]);
      `RCS_SRC_P33: primEvt = levelHit(use3[3], port3In[3], s_q.rctl[`RCS_RC_LEVEL]);
      `RCS_SRC_P27: primEvt = levelHit(use2[7], port2In[7], s_q.rctl[`RCS_RC_LEVEL]);
      `RCS_SRC_NORA, `RCS_SRC_NORB:
        primEvt = levelHit(1'b1, ~(|pin2[3:0]), s_q.rctl[`RCS_RC_LEVEL]);
      default: primEvt = 1'b0;
    endcase
    comboEvt = (s_q.combo[`RCS_CB_SEL_HI:`RCS_CB_SEL_LO] != 3'h0)
      && (comboLogic(s_q.combo[`RCS_CB_SEL_HI:`RCS_CB_SEL_LO], pin2, pin3)
      == s_q.combo[`RCS_CB_LEVEL]);
    changeEvt = s_q.latValid
      & (|((port2In ^ s_q.lat2) & s_q.p2Sel) | |((port3In ^ s_q.lat3) & s_q.p3Sel));
    wakeEvt = primEvt | comboEvt | changeEvt;
  end

  always_comb
  begin
    apbAcc = apbReq.psel & apbReq.penable;
    // only the first access cycle answers, giving exactly one wait state
    apbFirst = apbAcc & ~s_q.pready;
    wdat = apbReq.pwdata[7:0];
    apbHit = 1'b1;
    rdMux = '0;
    unique case (apbReq.paddr)
      `RCS_ADDR_VDET:
      begin
        rdMux[`RCS_VD_FILL_HI:`RCS_VD_FILL_LO] = `RCS_VDET_FILL;
        rdMux[`RCS_VD_HV] = s_q.hvFlag;
        rdMux[`RCS_VD_LV] = s_q.lvFlag;
        rdMux[`RCS_VD_EN] = s_q.vdEn;
      end
      `RCS_ADDR_RCTL:
      begin
        rdMux[7:0] = s_q.rctl;
        rdMux[`RCS_RC_STOP] = s_q.stopFlag;
      end
      `RCS_ADDR_P2SEL: rdMux[7:0] = s_q.p2Sel;
      `RCS_ADDR_COMBO: rdMux[7:0] = s_q.combo;
      `RCS_ADDR_P3SEL: rdMux[3:0] = s_q.p3Sel;
      `RCS_ADDR_ROUTE:
      begin
        rdMux[`RCS_RT_EN] = s_q.routeEn;
        rdMux[`RCS_RT_ONWR] = s_q.latOnWr;
        rdMux[`RCS_RT_VALID] = s_q.latValid;
      end
      `RCS_ADDR_IRQST: rdMux[`RCS_IRQ_LV] = s_q.lvPend;
      `RCS_ADDR_IRQMSK:
      begin
        rdMux[`RCS_IRQ_LV] = s_q.maskLv;
        rdMux[`RCS_IRQ_WAKE] = s_q.maskWake;
      end
      default: apbHit = 1'b0;
    endcase
  end

  always_comb
  begin
    s_d = s_q;
    s_d.pready = apbFirst;
    s_d.prdata = apbFirst ? rdMux : '0;
    s_d.pslverr = apbFirst & ~apbHit;
    // writes land on the edge that completes the access
    if (apbAcc && s_q.pready && apbReq.pwrite && apbHit)
    begin
      unique case (apbReq.paddr)
        `RCS_ADDR_VDET: s_d.vdEn = wdat[`RCS_VD_EN];
        `RCS_ADDR_RCTL:
        begin
          // stop flag lives apart; the stored copy keeps it and the unused bit at zero
          s_d.rctl = '0;
          s_d.rctl[`RCS_RC_LEVEL] = wdat[`RCS_RC_LEVEL];
          s_d.rctl[`RCS_RC_DELAY] = wdat[`RCS_RC_DELAY];
          s_d.rctl[`RCS_RC_SRC_HI:`RCS_RC_SRC_LO] = wdat[`RCS_RC_SRC_HI:`RCS_RC_SRC_LO];
          s_d.rctl[`RCS_RC_PRESC] = wdat[`RCS_RC_PRESC];
        end
        `RCS_ADDR_P2SEL: s_d.p2Sel = wdat;
        `RCS_ADDR_COMBO:
        begin
          s_d.combo = '0;
          s_d.combo[`RCS_CB_LEVEL] = wdat[`RCS_CB_LEVEL];
          s_d.combo[`RCS_CB_SEL_HI:`RCS_CB_SEL_LO] = wdat[`RCS_CB_SEL_HI:`RCS_CB_SEL_LO];
        end
        `RCS_ADDR_P3SEL: s_d.p3Sel = wdat[3:0];
        `RCS_ADDR_ROUTE: s_d.routeEn = wdat[`RCS_RT_EN];
        `RCS_ADDR_IRQST: s_d.lvPend = s_q.lvPend & ~wdat[`RCS_IRQ_LV];
        `RCS_ADDR_IRQMSK:
        begin
          s_d.maskLv = wdat[`RCS_IRQ_LV];
          s_d.maskWake = wdat[`RCS_IRQ_WAKE];
        end
        default: s_d = s_d;
      endcase
    end
    // change detectors follow the latest port access
    if (port2Rd | port3Rd | port2Wr | port3Wr)
    begin
      s_d.latValid = 1'b1;
      s_d.latOnWr = port2Wr | port3Wr;
    end
    if (port2Rd)
      s_d.lat2 = port2In;
    if (port2Wr)
      s_d.lat2 = port2WrData;
    if (port3Rd)
      s_d.lat3 = port3In;
    if (port3Wr)
      s_d.lat3 = port3WrData;
    // comparators sampled continuously, but never in stop
    if (s_q.vdEn && s_q.st != RCS_STOP)
    begin
      s_d.hvFlag = hvCompare;
      s_d.lvFlag = lvCompare;
    end
    else
    begin
      s_d.hvFlag = 1'b0;
      s_d.lvFlag = 1'b0;
    end
    // hardware set wins over a software clear in the same cycle
    if (s_q.vdEn && s_q.lvFlag && s_q.st != RCS_STOP)
      s_d.lvPend = 1'b1;
    s_d.lvIrq = s_d.lvPend & s_q.maskLv;
    s_d.wakePrev = wakeEvt;
    s_d.wakeIrq = s_q.routeEn & wakeEvt & ~s_q.wakePrev;
    s_d.p3b3Low = s_q.routeEn & wakeEvt;
    s_d.prescEn = s_q.rctl[`RCS_RC_PRESC];
    unique case (s_q.st)
      RCS_HOLD:
      begin
        s_d.sysRstN = 1'b0;
        s_d.tmr = TMR_LOAD;
        if (!brownOut && !porReq)
          s_d.st = RCS_TIMING;
      end
      RCS_TIMING:
      begin
        s_d.sysRstN = 1'b0;
        if (s_q.tmr == '0)
        begin
          s_d.st = RCS_RUN;
          s_d.sysRstN = 1'b1;
          s_d.cpuClkEn = 1'b1;
        end
        else
          s_d.tmr = s_q.tmr - 1'b1;
      end
      RCS_RUN:
      begin
        if (stopReq)
        begin
          s_d.st = RCS_STOP;
          s_d.cpuClkEn = 1'b0;
          s_d.oscEn = 1'b0;
          s_d.prescEn = 1'b0;
        end
        else if (haltReq)
        begin
          s_d.st = RCS_HALT;
          s_d.cpuClkEn = 1'b0;
        end
      end
      RCS_HALT:
      begin
        // oscillator and interrupt logic stay up; only the cpu clock is held
        if (irqPending | s_d.lvIrq | (s_q.maskWake & s_d.wakeIrq))
        begin
          s_d.st = RCS_RUN;
          s_d.cpuClkEn = 1'b1;
        end
      end
      RCS_STOP:
      begin
        if (wakeEvt)
        begin
          // recovery reset: defaults except the kept bits
          s_d = fullDefault();
          s_d.stopFlag = 1'b1;
          s_d.rctl[`RCS_RC_SRC_HI:`RCS_RC_SRC_LO] = s_q.rctl[`RCS_RC_SRC_HI:`RCS_RC_SRC_LO];
          s_d.rctl[`RCS_RC_PRESC] = 1'b0;
          s_d.rstAddr = `RCS_RESTART_ADDR;
          s_d.wakePrev = 1'b1;
          if (!s_q.rctl[`RCS_RC_DELAY])
          begin
            // bypass: caller guarantees a stable clock, no settling wait
            s_d.st = RCS_RUN;
            s_d.sysRstN = 1'b1;
            s_d.cpuClkEn = 1'b1;
          end
        end
      end
    endcase
    if (wdtTimeout && s_q.st != RCS_HOLD)
    begin
      s_d = fullDefault();
      if (s_q.st == RCS_STOP)
        s_d.rstAddr = `RCS_RESTART_ADDR;
    end
    if (brownOut || porReq)
    begin
      s_d = fullDefault();
      s_d.st = RCS_HOLD;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!nrst)
      s_q <= fullDefault();
    else
      s_q <= s_d;
  end

  assign apbRsp.prdata = s_q.prdata;
  assign apbRsp.pready = s_q.pready;
  assign apbRsp.pslverr = s_q.pslverr;
  assign sysRstN = s_q.sysRstN;
  assign cpuClkEn = s_q.cpuClkEn;
  assign oscEn = s_q.oscEn;
  assign prescaleEn = s_q.prescEn;
  assign restartAddr = s_q.rstAddr;
  assign lowVoltageIrq = s_q.lvIrq;
  assign wakeIrq = s_q.wakeIrq;
  assign port3Bit3Low = s_q.p3b3Low;

endmodule : rcs_sequencer

// *** tb/rcs_checker.sv ***
`timescale 1ns/1ps
`include "rcs_regs.svh"
module rcs_checker #(
  parameter int unsigned STARTUP_CYCLES = 8
) (
  input wire logic core_clk,
  input wire logic nrst,
  input wire rcs_pkg::rcs_apb_req_t apbReq,
  input wire rcs_pkg::rcs_apb_rsp_t apbRsp,
  input wire logic brownOut,
  input wire logic haltReq,
  input wire logic stopReq,
  input wire logic irqPending,
  input wire logic sysRstN,
  input wire logic cpuClkEn,
  input wire logic oscEn,
  input wire logic prescaleEn,
  input wire logic wakeIrq,
  input wire logic port3Bit3Low
);
  import rcs_pkg::*;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);
  sequence s_setup;
    apbReq.psel && !apbReq.penable ##1 apbReq.psel && apbReq.penable;
  endsequence
  sequence s_halted;
    !cpuClkEn && oscEn && sysRstN;
  endsequence
  property p_apb_answer;
    s_setup |=> apbRsp.pready;
  endproperty
  a_apb_answer: assert property (p_apb_answer) else $error("late apb answer");
  property p_apb_pulse;
    apbRsp.pready |=> !apbRsp.pready;
  endproperty
  a_apb_pulse: assert property (p_apb_pulse) else $error("pready longer than one cycle");
  property p_vdet_fill;
    apbRsp.pready && !apbReq.pwrite && apbReq.paddr == `RCS_ADDR_VDET |-> apbRsp.prdata[7:3] == 5'h1f;
  endproperty
  a_vdet_fill: assert property (p_vdet_fill) else $error("vdet upper bits not ones");
  property p_brown_hold;
    brownOut [*2] |=> !sysRstN;
  endproperty
  a_brown_hold: assert property (p_brown_hold) else $error("reset not held");
  property p_rst_gate;
    !sysRstN |-> !cpuClkEn;
  endproperty
  a_rst_gate: assert property (p_rst_gate) else $error("cpu clock runs in reset");
  property p_halt;
    cpuClkEn && sysRstN && haltReq && !stopReq |=> !cpuClkEn && oscEn;
  endproperty
  a_halt: assert property (p_halt) else $error("halt entry wrong");
  property p_stop;
    cpuClkEn && sysRstN && stopReq |=> !cpuClkEn && !oscEn;
  endproperty
  a_stop: assert property (p_stop) else $error("stop entry wrong");
  property p_halt_exit;
    (s_halted ##0 irqPending) |-> ##[1:2] cpuClkEn;
  endproperty
  a_halt_exit: assert property (p_halt_exit) else $error("halt not left");
  property p_wake_route;
    wakeIrq |-> port3Bit3Low;
  endproperty
  a_wake_route: assert property (p_wake_route) else $error("wake pin not driven");
  property p_presc;
    $rose(oscEn) |=> !prescaleEn;
  endproperty
  a_presc: assert property (p_presc) else $error("prescaler kept on");
endmodule : rcs_checker
bind rcs_sequencer rcs_checker #(.STARTUP_CYCLES(STARTUP_CYCLES)) i_chk (.core_clk, .nrst,
  .apbReq, .apbRsp, .brownOut, .haltReq, .stopReq, .irqPending, .sysRstN, .cpuClkEn, .oscEn,
  .prescaleEn, .wakeIrq, .port3Bit3Low);

// *** tb/rcs_core_model.sv ***
`timescale 1ns/1ps
module rcs_core_model (
  input wire logic core_clk,
  input wire logic [1:0] op,
  output logic haltReq,
  output logic stopReq
);
  logic [1:0] pendOp_q = 2'h0;
  // one idle cycle stands for the flushing no-op before the sleep opcode
  always @(posedge core_clk)
  begin
    pendOp_q <= op;
    haltReq <= (pendOp_q == 2'h1);
    stopReq <= (pendOp_q == 2'h2);
  end
endmodule : rcs_core_model

// *** tb/reset_cause_and_stop_recovery_test.sv ***
`timescale 1ns/1ps
`include "rcs_regs.svh"
`define CHK(g, e) begin nTests++; if ((g) !== (e)) begin fails++; $display("mismatch t=%0t got %h exp %h", $time, g, e); end end
module reset_cause_and_stop_recovery_test;
  import rcs_pkg::*;
  logic core_clk = 1'h0;
  logic nrst = 1'h0;
  rcs_apb_req_t req = '0;
  rcs_apb_rsp_t rsp;
  logic porReq = 1'h0, brownOut = 1'h0, wdtTimeout = 1'h0, lvCompare = 1'h0, hvCompare = 1'h0;
  logic irqPending = 1'h0, port2Wr = 1'h0, port3Rd = 1'h0;
  logic [7:0] port2In = 8'h00;
  logic [3:0] port3In = 4'hf;
  logic [3:0] port3IsOutput = 4'h0;
  logic [1:0] op = 2'h0;
  logic haltReq, stopReq, sysRstN, cpuClkEn, oscEn, prescaleEn, lowVoltageIrq, wakeIrq;
  logic port3Bit3Low, lastErr;
  logic [11:0] restartAddr;
  logic [31:0] d;
  int fails = 0;
  int nTests = 0;
  int k;
  rcs_sequencer #(.STARTUP_CYCLES(8)) i_dut (.core_clk(core_clk), .nrst(nrst), .apbReq(req),
    .apbRsp(rsp), .porReq(porReq), .brownOut(brownOut), .wdtTimeout(wdtTimeout),
    .lvCompare(lvCompare), .hvCompare(hvCompare), .haltReq(haltReq), .stopReq(stopReq),
    .irqPending(irqPending), .port2In(port2In), .port3In(port3In), .port2IsOutput(8'h00),
    .port3IsOutput(port3IsOutput), .port2Rd(1'h0), .port2Wr(port2Wr), .port2WrData(port2In),
    .port3Rd(port3Rd), .port3Wr(1'h0), .port3WrData(4'h0), .sysRstN(sysRstN),
    .cpuClkEn(cpuClkEn), .oscEn(oscEn), .prescaleEn(prescaleEn), .restartAddr(restartAddr),
    .lowVoltageIrq(lowVoltageIrq), .wakeIrq(wakeIrq), .port3Bit3Low(port3Bit3Low));
  rcs_core_model i_core (.core_clk(core_clk), .op(op), .haltReq(haltReq), .stopReq(stopReq));
  initial forever #25 core_clk = ~core_clk;
  task cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask : cyc
  task apb(input logic w, input logic [11:0] a, input logic [7:0] wd);
    @(posedge core_clk);
    req <= '{psel: 1'h1, penable: 1'h0, pwrite: w, paddr: a, pwdata: {24'h0, wd}};
    @(posedge core_clk);
    req.penable <= 1'h1;
    do @(posedge core_clk); while (rsp.pready !== 1'h1);
    d = rsp.prdata;
    lastErr = rsp.pslverr;
    req.psel <= 1'h0;
    req.penable <= 1'h0;
  endtask : apb
  task wr(input logic [11:0] a, input logic [7:0] v);
    apb(1'h1, a, v);
  endtask : wr
  task rd(input logic [11:0] a, input logic [7:0] e);
    apb(1'h0, a, 8'h00);
    `CHK(d, {24'h0, e})
  endtask : rd
  // sleep request through the core model, which inserts the no-op cycle
  task sleep(input logic [1:0] o);
    op <= o;
    cyc(1);
    op <= 2'h0;
    cyc(4);
  endtask : sleep
  task waitRun();
    for (k = 0; k < 50 && sysRstN !== 1'h1; k++) cyc(1);
  endtask : waitRun
  task results();
    $display("comparisons %0d mismatches %0d", nTests, fails);
    if (fails == 0 && nTests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : results
  initial
  begin
    #200000;
    fails++;
    results();
  end
  initial
  begin
    cyc(2);
    nrst <= 1'h1;
    cyc(12);
    rd(`RCS_ADDR_RCTL, 8'h20);
    rd(`RCS_ADDR_VDET, 8'hf8);
    wr(`RCS_ADDR_VDET, 8'hff);
    rd(`RCS_ADDR_VDET, 8'hf9);
    apb(1'h0, 12'h0f0, 8'h00);
    `CHK(lastErr, 1'h1)
    $display("test registers done");
    lvCompare <= 1'h1;
    hvCompare <= 1'h1;
    cyc(3);
    rd(`RCS_ADDR_VDET, 8'hff);
    rd(`RCS_ADDR_IRQST, 8'h01);
    `CHK(lowVoltageIrq, 1'h0)
    wr(`RCS_ADDR_IRQMSK, 8'h01);
    cyc(2);
    `CHK(lowVoltageIrq, 1'h1)
    lvCompare <= 1'h0;
    hvCompare <= 1'h0;
    cyc(2);
    wr(`RCS_ADDR_IRQST, 8'h01);
    rd(`RCS_ADDR_IRQST, 8'h00);
    `CHK(lowVoltageIrq, 1'h0)
    wr(`RCS_ADDR_VDET, 8'h00);
    $display("test voltage done");
    sleep(2'h1);
    `CHK(cpuClkEn, 1'h0)
    `CHK(oscEn, 1'h1)
    irqPending <= 1'h1;
    cyc(3);
    `CHK(cpuClkEn, 1'h1)
    irqPending <= 1'h0;
    $display("test halt done");
    wr(`RCS_ADDR_RCTL, 8'h09);
    wr(`RCS_ADDR_ROUTE, 8'h10);
    port3In <= 4'hd;
    cyc(2);
    `CHK(wakeIrq, 1'h1)
    cyc(1);
    `CHK(port3Bit3Low, 1'h1)
    `CHK(prescaleEn, 1'h1)
    port3IsOutput <= 4'h2;
    cyc(2);
    `CHK(port3Bit3Low, 1'h0)
    `CHK(wakeIrq, 1'h0)
    port3IsOutput <= 4'h0;
    port3In <= 4'hf;
    wr(`RCS_ADDR_COMBO, 8'h1a);
    cyc(2);
    `CHK(port3Bit3Low, 1'h1)
    rd(`RCS_ADDR_COMBO, 8'h1a);
    wr(`RCS_ADDR_COMBO, 8'h00);
    cyc(2);
    `CHK(port3Bit3Low, 1'h0)
    sleep(2'h2);
    `CHK(oscEn, 1'h0)
    port3In <= 4'hd;
    cyc(10);
    port3In <= 4'hf;
    `CHK(oscEn, 1'h1)
    `CHK(sysRstN, 1'h1)
    `CHK(restartAddr, 12'h00c)
    `CHK(prescaleEn, 1'h0)
    rd(`RCS_ADDR_RCTL, 8'ha8);
    $display("test fast recovery done");
    wr(`RCS_ADDR_P2SEL, 8'h01);
    port2Wr <= 1'h1;
    cyc(1);
    port2Wr <= 1'h0;
    rd(`RCS_ADDR_ROUTE, 8'h03);
    port3Rd <= 1'h1;
    cyc(1);
    port3Rd <= 1'h0;
    rd(`RCS_ADDR_ROUTE, 8'h01);
    sleep(2'h2);
    port2In <= 8'h01;
    cyc(3);
    `CHK(sysRstN, 1'h0)
    waitRun();
    `CHK(sysRstN, 1'h1)
    `CHK(restartAddr, 12'h00c)
    $display("test delayed recovery done");
    wdtTimeout <= 1'h1;
    cyc(1);
    wdtTimeout <= 1'h0;
    cyc(2);
    waitRun();
    rd(`RCS_ADDR_RCTL, 8'h20);
    `CHK(restartAddr, 12'h000)
    brownOut <= 1'h1;
    porReq <= 1'h1;
    cyc(3);
    `CHK(sysRstN, 1'h0)
    brownOut <= 1'h0;
    porReq <= 1'h0;
    cyc(2);
    `CHK(sysRstN, 1'h0)
    waitRun();
    `CHK(sysRstN, 1'h1)
    $display("test full resets done");
    results();
  end
endmodule : reset_cause_and_stop_recovery_test
